// ===== verilog/lpic_top.sv
// Operation
// - Command ports decoded at I/O 20h primary and A0h secondary.
// - Command write with bit 4 set starts initialization.
// - Exactly three further data-port bytes complete initialization.
// - After initialization a request needs a rising input transition.
// - Init clears mask, bottom priority 7, cascade id 7, special mask, reads request.
// - Second init byte gives vector bits 7:3 per controller.
// - Secondary matches broadcast id against stored cascade byte, then supplies vector.
// - Operation words load mask, rotate and end service, select reads and poll.
// - Fully nested: input 0 highest; acknowledge picks winner, sets in-service.
// - In-service blocks equal or lower priority; higher still interrupts.
// - Auto end clears in-service at end of second acknowledge step (ACK_SECOND).
// - Special fully nested lets in-service secondary still raise higher requests.
// - Automatic rotation gives serviced primary input the lowest priority.
// - Code 101b rotates on non-specific end; 100b enables auto-end rotation.
// - Code 11xb sets bottom priority level; 111b also ends that level.
// - Poll freezes requests until next read, which acknowledges and returns level.
// - Global trigger bit ignored; per-input bits pick edge or level.
// - Request gone before first acknowledge ends returns default vector 7.
// - Primary broadcasts three-bit cascade id at end of first acknowledge.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "lpic_params.svh"

module lpic_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  irq_primary,
    input  wire logic [7:0]  irq_secondary,
    input  wire logic        acknowledge_pulse,
    output logic             cpu_interrupt_output,
    output logic [7:0]       ack_vector,
    output logic             ack_vector_valid
);

    function automatic logic [2:0] lpic_rank(input logic [2:0] lvl, input logic [2:0] bot);
        return 3'(lvl - bot - 3'h1);
    endfunction : lpic_rank

    // Highest-priority set bit given bottom level; {found, level}
    function automatic logic [3:0] lpic_pick(input logic [7:0] v, input logic [2:0] bot);
        logic [3:0] r;
        logic [2:0] lv;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            lv = 3'(bot + 3'(i) + 3'h1);
            if (v[lv]) begin
                r = {1'b1, lv};
            end
        end
        return r;
    endfunction : lpic_pick

    function automatic logic [11:0] lpic_byte(input logic [11:0] idx);
        return 12'(idx << 2);
    endfunction : lpic_byte

    // Pin synchronisers
    logic [7:0] meta_ff [2];
    logic [7:0] sync_ff [2];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '{8'h00, 8'h00};
            sync_ff <= '{8'h00, 8'h00};
        end else begin
            meta_ff[0] <= irq_primary;
            meta_ff[1] <= irq_secondary;
            sync_ff    <= meta_ff;
        end
    end

    // State
    logic [7:0]  irr_ff [2];
    logic [7:0]  isr_ff [2];
    logic [7:0]  imr_ff [2];
    logic [7:0]  prev_ff [2];
    logic [7:0]  armed_ff [2];
    logic [7:0]  trig_ff [2];
    logic [7:0]  casc_ff [2];
    logic [4:0]  base_ff [2];
    logic [2:0]  bot_ff [2];
    logic [1:0]  step_ff [2];
    logic [1:0]  auto_end_of_interrupt_ff, sfnm_ff, pm_ff, smm_ff, rotae_ff, rdisr_ff, poll_ff;
    logic [2:0]  srv_lvl_ff [2];
    logic [1:0]  srv_vld_ff;
    logic [2:0]  cas_id_ff;
    logic        cas_vld_ff;
    logic [7:0]  vec_ff;
    logic [7:0]  ack_vector_ff;
    logic        ack_valid_ff;
    logic        int_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    lpic_pkg::lpic_ack_state_t ack_st_ff;

    // Bus decode
    logic       acc, hit, is_data, is_trig, csel;
    logic [7:0] wd;
    logic [1:0] wr_cmd, wr_dat, rd_c, init_w, op2_w, op3_w;
    always_comb begin
        acc     = psel & penable & pready_ff;
        wd      = pwdata[7:0];
        hit     = 1'b1;
        is_data = 1'b0;
        is_trig = 1'b0;
        csel    = 1'b0;
        unique case (paddr)
            lpic_byte(`LPIC_IDX_PRI_CMD):  csel = 1'b0;
            lpic_byte(`LPIC_IDX_PRI_DATA): is_data = 1'b1;
            lpic_byte(`LPIC_IDX_SEC_CMD):  csel = 1'b1;
            lpic_byte(`LPIC_IDX_SEC_DATA): begin
                is_data = 1'b1;
                csel    = 1'b1;
            end
            lpic_byte(`LPIC_IDX_TRIG_PRI): is_trig = 1'b1;
            lpic_byte(`LPIC_IDX_TRIG_SEC): begin
                is_trig = 1'b1;
                csel    = 1'b1;
            end
            default: hit = 1'b0;
        endcase
        for (int c = 0; c < 2; c++) begin
            wr_cmd[c] = acc & hit & pwrite & ~is_trig & ~is_data & (csel == 1'(c));
            wr_dat[c] = acc & hit & pwrite & ~is_trig & is_data & (csel == 1'(c));
            rd_c[c]   = acc & hit & ~pwrite & ~is_trig & (csel == 1'(c));
            init_w[c] = wr_cmd[c] & wd[`LPIC_BIT_INIT];
            op2_w[c]  = wr_cmd[c] & ~wd[`LPIC_BIT_INIT] & ~wd[`LPIC_BIT_SEL3];
            op3_w[c]  = wr_cmd[c] & ~wd[`LPIC_BIT_INIT] & wd[`LPIC_BIT_SEL3];
        end
    end

    // Priority resolution
    logic [7:0] req_v [2];
    logic [7:0] blk_v [2];
    logic [3:0] win [2];
    logic [3:0] top [2];
    logic [3:0] nsp [2];
    logic [1:0] int_c, frz;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            req_v[c] = irr_ff[c] & ~imr_ff[c];
        end
        // Secondary resolved first; its output feeds primary input 2
        for (int c = 1; c >= 0; c--) begin
            if (c == 0) begin
                req_v[0][2] = int_c[1] & ~imr_ff[0][2];
            end
            blk_v[c] = smm_ff[c] ? (isr_ff[c] & ~imr_ff[c]) : isr_ff[c];
            win[c]   = lpic_pick(req_v[c], bot_ff[c]);
            top[c]   = lpic_pick(blk_v[c], bot_ff[c]);
            nsp[c]   = top[c];
            frz[c]   = (ack_st_ff != lpic_pkg::ACK_IDLE) | poll_ff[c];
            int_c[c] = win[c][3] & (~top[c][3]
                       | (lpic_rank(win[c][2:0], bot_ff[c]) < lpic_rank(top[c][2:0], bot_ff[c]))
                       | ((c == 0) & sfnm_ff[0] & (win[c][2:0] == 3'h2) & (top[c][2:0] == 3'h2)));
        end
    end

    // Acknowledge and poll effects on service bits
    logic [7:0] set_isr [2];
    logic [7:0] clr_isr [2];
    logic       sec_match;
    always_comb begin
        sec_match = cas_vld_ff & (casc_ff[1][2:0] == cas_id_ff);
        for (int c = 0; c < 2; c++) begin
            set_isr[c] = 8'h00;
            clr_isr[c] = 8'h00;
            if (rd_c[c] & poll_ff[c] & win[c][3]) begin
                set_isr[c][win[c][2:0]] = 1'b1;
            end
            if (op2_w[c]) begin
                unique case (wd[7:5])
                    `LPIC_OP_NS_EOI, `LPIC_OP_ROT_NS_EOI: begin
                        if (nsp[c][3]) begin
                            clr_isr[c][nsp[c][2:0]] = 1'b1;
                        end
                    end
                    `LPIC_OP_SP_EOI, `LPIC_OP_ROT_SP_EOI: clr_isr[c][wd[2:0]] = 1'b1;
                    default: ;
                endcase
            end
            if ((ack_st_ff == lpic_pkg::ACK_SECOND) & auto_end_of_interrupt_ff[c] & srv_vld_ff[c]) begin
                clr_isr[c][srv_lvl_ff[c]] = 1'b1;
            end
        end
        if ((ack_st_ff == lpic_pkg::ACK_FIRST) & int_c[0]) begin
            set_isr[0][win[0][2:0]] = 1'b1;
        end
        if ((ack_st_ff == lpic_pkg::ACK_SECOND) & sec_match & int_c[1] & ~auto_end_of_interrupt_ff[1]) begin
            set_isr[1][win[1][2:0]] = 1'b1;
        end
    end

    // Request and in-service registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irr_ff   <= '{8'h00, 8'h00};
            isr_ff   <= '{8'h00, 8'h00};
            prev_ff  <= '{8'hFF, 8'hFF};
            armed_ff <= '{8'h00, 8'h00};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (init_w[c]) begin
                    irr_ff[c]   <= 8'h00;
                    isr_ff[c]   <= 8'h00;
                    prev_ff[c]  <= 8'hFF;
                    armed_ff[c] <= 8'h00;
                end else begin
                    isr_ff[c] <= (isr_ff[c] & ~clr_isr[c]) | set_isr[c];
                    if (frz[c]) begin
                        irr_ff[c] <= irr_ff[c] & ~set_isr[c];
                    end else begin
                        prev_ff[c]  <= sync_ff[c];
                        armed_ff[c] <= armed_ff[c] | ~sync_ff[c];
                        irr_ff[c]   <= ((trig_ff[c] & sync_ff[c] & armed_ff[c])
                                       | (~trig_ff[c] & (irr_ff[c] | (sync_ff[c] & ~prev_ff[c]))))
                                       & ~set_isr[c];
                    end
                end
            end
        end
    end

    // Per-input trigger select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_ff <= '{8'h00, 8'h00};
        end else if (acc & hit & pwrite & is_trig) begin
            trig_ff[csel] <= wd & (csel ? `LPIC_TRIG_MASK_SEC : `LPIC_TRIG_MASK_PRI);
        end
    end

    // Init sequence and operation words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imr_ff   <= '{8'h00, 8'h00};
            casc_ff  <= '{`LPIC_RST_CASCADE, `LPIC_RST_CASCADE};
            base_ff  <= '{5'h00, 5'h00};
            bot_ff   <= '{`LPIC_RST_BOTTOM, `LPIC_RST_BOTTOM};
            step_ff  <= '{2'h0, 2'h0};
            auto_end_of_interrupt_ff  <= 2'h0;
            sfnm_ff  <= 2'h0;
            pm_ff    <= 2'h0;
            smm_ff   <= 2'h0;
            rotae_ff <= 2'h0;
            rdisr_ff <= 2'h0;
            poll_ff  <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (init_w[c]) begin
                    step_ff[c]  <= 2'h1;
                    imr_ff[c]   <= 8'h00;
                    bot_ff[c]   <= `LPIC_RST_BOTTOM;
                    casc_ff[c]  <= `LPIC_RST_CASCADE;
                    smm_ff[c]   <= 1'b0;
                    rdisr_ff[c] <= 1'b0;
                    poll_ff[c]  <= 1'b0;
                end else if (wr_dat[c] & (step_ff[c] != 2'h0)) begin
                    unique case (step_ff[c])
                        2'h1: base_ff[c] <= wd[7:3];
                        2'h2: casc_ff[c] <= wd;
                        default: begin
                            pm_ff[c]   <= wd[`LPIC_BIT_PM];
                            auto_end_of_interrupt_ff[c] <= wd[`LPIC_BIT_AUTO_END_OF_INTERRUPT];
                            sfnm_ff[c] <= wd[`LPIC_BIT_SFNM];
                        end
                    endcase
                    step_ff[c] <= 2'(step_ff[c] + 2'h1);
                end else begin
                    if (wr_dat[c]) begin
                        imr_ff[c] <= wd;
                    end
                    if (op2_w[c]) begin
                        unique case (wd[7:5])
                            `LPIC_OP_ROT_NS_EOI: begin
                                if (nsp[c][3]) begin
                                    bot_ff[c] <= nsp[c][2:0];
                                end
                            end
                            `LPIC_OP_SET_PRIO, `LPIC_OP_ROT_SP_EOI: bot_ff[c] <= wd[2:0];
                            `LPIC_OP_ROT_AUTO_END_OF_INTERRUPT_SET: rotae_ff[c] <= 1'b1;
                            `LPIC_OP_ROT_AUTO_END_OF_INTERRUPT_CLR: rotae_ff[c] <= 1'b0;
                            default: ;
                        endcase
                    end
                    if ((ack_st_ff == lpic_pkg::ACK_SECOND) & auto_end_of_interrupt_ff[c] & rotae_ff[c] & srv_vld_ff[c]) begin
                        bot_ff[c] <= srv_lvl_ff[c];
                    end
                    if (op3_w[c]) begin
                        if (wd[`LPIC_BIT_ESMM]) begin
                            smm_ff[c] <= wd[`LPIC_BIT_SMM];
                        end
                        if (wd[`LPIC_BIT_RR]) begin
                            rdisr_ff[c] <= wd[`LPIC_BIT_RIS];
                        end
                    end
                    if (op3_w[c] & wd[`LPIC_BIT_POLL]) begin
                        poll_ff[c] <= 1'b1;
                    end else if (rd_c[c]) begin
                        poll_ff[c] <= 1'b0;
                    end
                end
            end
        end
    end

    // Acknowledge sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_st_ff     <= lpic_pkg::ACK_IDLE;
            cas_id_ff     <= 3'h0;
            cas_vld_ff    <= 1'b0;
            vec_ff        <= 8'h00;
            ack_vector_ff <= 8'h00;
            ack_valid_ff  <= 1'b0;
            srv_lvl_ff    <= '{3'h0, 3'h0};
            srv_vld_ff    <= 2'h0;
        end else begin
            ack_valid_ff <= 1'b0;
            unique case (ack_st_ff)
                lpic_pkg::ACK_IDLE: begin
                    if (acknowledge_pulse) begin
                        ack_st_ff <= lpic_pkg::ACK_FIRST;
                    end
                end
                lpic_pkg::ACK_FIRST: begin
                    ack_st_ff     <= lpic_pkg::ACK_SECOND;
                    srv_lvl_ff[0] <= win[0][2:0];
                    srv_vld_ff    <= {1'b0, int_c[0]};
                    cas_vld_ff    <= int_c[0] & casc_ff[0][win[0][2:0]];
                    cas_id_ff     <= win[0][2:0];
                    if (int_c[0] & ~casc_ff[0][win[0][2:0]]) begin
                        vec_ff <= {base_ff[0], win[0][2:0]};
                    end else begin
                        vec_ff <= {base_ff[0], `LPIC_DEFAULT_LEVEL};
                    end
                end
                default: begin
                    ack_st_ff    <= lpic_pkg::ACK_IDLE;
                    ack_valid_ff <= 1'b1;
                    cas_vld_ff   <= 1'b0;
                    if (sec_match & int_c[1]) begin
                        ack_vector_ff <= {base_ff[1], win[1][2:0]};
                    end else begin
                        ack_vector_ff <= vec_ff;
                    end
                end
            endcase
        end
    end

    // Bus slave, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & ~hit;
            if (psel & penable & ~pready_ff & ~pwrite) begin
                if (!hit) begin
                    prdata_ff <= 32'h0000_0000;
                end else if (is_trig) begin
                    prdata_ff <= {24'h00_0000, trig_ff[csel]};
                end else if (is_data) begin
                    prdata_ff <= {24'h00_0000, imr_ff[csel]};
                end else if (poll_ff[csel]) begin
                    prdata_ff <= {24'h00_0000, win[csel][3], 4'h0, win[csel][2:0]};
                end else begin
                    prdata_ff <= {24'h00_0000, rdisr_ff[csel] ? isr_ff[csel] : irr_ff[csel]};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ff <= 1'b0;
        end else begin
            int_ff <= int_c[0];
        end
    end

    assign prdata               = prdata_ff;
    assign pready               = pready_ff;
    assign pslverr              = pslverr_ff;
    assign cpu_interrupt_output = int_ff;
    assign ack_vector           = ack_vector_ff;
    assign ack_vector_valid     = ack_valid_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ack_start;
        acknowledge_pulse && (ack_st_ff == lpic_pkg::ACK_IDLE);
    endsequence
    sequence s_ack_steps;
        (ack_st_ff == lpic_pkg::ACK_FIRST) ##1 (ack_st_ff == lpic_pkg::ACK_SECOND) ##1 ack_valid_ff;
    endsequence

    property p_init_start;
        wr_cmd[1] && wd[`LPIC_BIT_INIT] |=> step_ff[1] == 2'h1;
    endproperty
    a_init_start: assert property (p_init_start) else $error("init start missed");

    property p_init_len;
        (step_ff[0] == 2'h3) && wr_dat[0] |=> (step_ff[0] == 2'h0) && (pm_ff[0] == $past(wd[0]));
    endproperty
    a_init_len: assert property (p_init_len) else $error("init sequence length wrong");

    property p_init_clear;
        init_w[0] |=> (imr_ff[0] == 8'h00) && (bot_ff[0] == 3'h7) && (casc_ff[0] == 8'h07) && !smm_ff[0];
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("init did not clear state");

    property p_ack_seq;
        s_ack_start |=> s_ack_steps;
    endproperty
    a_ack_seq: assert property (p_ack_seq) else $error("acknowledge sequence broken");

    property p_spurious;
        (ack_st_ff == lpic_pkg::ACK_FIRST) && !int_c[0] |=> ##1 ack_vector_ff == {base_ff[0], 3'h7};
    endproperty
    a_spurious: assert property (p_spurious) else $error("default vector not returned");

    property p_auto_end_of_interrupt;
        (ack_st_ff == lpic_pkg::ACK_SECOND) && auto_end_of_interrupt_ff[0] && srv_vld_ff[0] && !init_w[0]
            |=> !isr_ff[0][$past(srv_lvl_ff[0])];
    endproperty
    a_auto_end_of_interrupt: assert property (p_auto_end_of_interrupt) else $error("auto end left in-service set");

    property p_poll_freeze;
        poll_ff[0] && !init_w[0] && !rd_c[0] |=> $stable(irr_ff[0]);
    endproperty
    a_poll_freeze: assert property (p_poll_freeze) else $error("requests moved while polled");

    property p_set_prio;
        op2_w[0] && (wd[7:5] == 3'h6) |=> bot_ff[0] == $past(wd[2:0]);
    endproperty
    a_set_prio: assert property (p_set_prio) else $error("bottom priority not loaded");

endmodule : lpic_top

// ===== verilog/lpic_params.svh
`ifndef LPIC_PARAMS_SVH
`define LPIC_PARAMS_SVH

// Port indices; byte address is four times the index
`define LPIC_IDX_PRI_CMD      12'h020
`define LPIC_IDX_PRI_DATA     12'h021
`define LPIC_IDX_SEC_CMD      12'h0A0
`define LPIC_IDX_SEC_DATA     12'h0A1
`define LPIC_IDX_TRIG_PRI     12'h0D0
`define LPIC_IDX_TRIG_SEC     12'h0D1

// Command byte fields
`define LPIC_BIT_INIT         4
`define LPIC_BIT_SEL3         3
`define LPIC_BIT_ESMM         6
`define LPIC_BIT_SMM          5
`define LPIC_BIT_POLL         2
`define LPIC_BIT_RR           1
`define LPIC_BIT_RIS          0
`define LPIC_BIT_PM           0
`define LPIC_BIT_AUTO_END_OF_INTERRUPT         1
`define LPIC_BIT_SFNM         4

// Rotate / end-of-interrupt codes
`define LPIC_OP_NS_EOI        3'h1
`define LPIC_OP_SP_EOI        3'h3
`define LPIC_OP_ROT_AUTO_END_OF_INTERRUPT_SET  3'h4
`define LPIC_OP_ROT_NS_EOI    3'h5
`define LPIC_OP_SET_PRIO      3'h6
`define LPIC_OP_ROT_SP_EOI    3'h7
`define LPIC_OP_ROT_AUTO_END_OF_INTERRUPT_CLR  3'h0

// Reset and init values
`define LPIC_RST_BOTTOM       3'h7
`define LPIC_RST_CASCADE      8'h07
`define LPIC_DEFAULT_LEVEL    3'h7
// Trigger bits that can select level mode; cleared bits stay edge mode
`define LPIC_TRIG_MASK_PRI    8'hFA
`define LPIC_TRIG_MASK_SEC    8'hFE

`endif

// ===== verilog/lpic_pkg.sv
package lpic_pkg;

    typedef enum logic [1:0] {
        ACK_IDLE,
        ACK_FIRST,
        ACK_SECOND
    } lpic_ack_state_t;

endpackage : lpic_pkg

// ===== tb/lpic_host_model.sv
`timescale 1ns/1ps

// Host side of the acknowledge cycle: one pulse, then wait for the vector
module lpic_host_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ack_go,
    input  wire logic       ack_vector_valid,
    input  wire logic [7:0] ack_vector,
    output logic            acknowledge_pulse,
    output logic            busy_ff,
    output logic      [7:0] vec_ff
);
    // Single-cycle pulse, never while a cycle is open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acknowledge_pulse <= 1'b0;
        end else begin
            acknowledge_pulse <= ack_go & ~busy_ff & ~acknowledge_pulse;
        end
    end

    // Busy from pulse to vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff <= 1'b0;
            vec_ff  <= 8'h00;
        end else if (ack_vector_valid) begin
            busy_ff <= 1'b0;
            vec_ff  <= ack_vector;
        end else if (ack_go & ~busy_ff) begin
            busy_ff <= 1'b1;
        end
    end
endmodule : lpic_host_model

// ===== tb/cascaded_legacy_pic_programming_tb_top.sv
`timescale 1ns/1ps
`include "lpic_params.svh"

module cascaded_legacy_pic_programming_tb_top;
    localparam logic [11:0] PC = `LPIC_IDX_PRI_CMD << 2;
    localparam logic [11:0] PD = `LPIC_IDX_PRI_DATA << 2;
    localparam logic [11:0] SC = `LPIC_IDX_SEC_CMD << 2;
    localparam logic [11:0] SD = `LPIC_IDX_SEC_DATA << 2;
    localparam logic [11:0] TP = `LPIC_IDX_TRIG_PRI << 2;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        ack_go, ack_busy, acknowledge_pulse, cpu_interrupt_output, ack_vector_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  irq_primary, irq_secondary, ack_vector, got_vector;
    int          miscompares, tests_run, cycles;

    lpic_top u_lpic_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq_primary, .irq_secondary, .acknowledge_pulse, .cpu_interrupt_output, .ack_vector,
        .ack_vector_valid);
    lpic_host_model u_lpic_host_model (.pclk, .presetn, .ack_go, .ack_vector_valid, .ack_vector,
        .acknowledge_pulse, .busy_ff(ack_busy), .vec_ff(got_vector));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task complete_run;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task ack(input logic [7:0] exp);
        @(posedge pclk);
        ack_go <= 1'b1;
        @(posedge pclk);
        ack_go <= 1'b0;
        @(posedge pclk);
        while (ack_busy !== 1'b0) @(posedge pclk);
        chk({24'h000000, got_vector}, {24'h000000, exp});
    endtask : ack

    task wait_int(input logic exp);
        repeat (8) @(posedge pclk);
        chk({31'h0, cpu_interrupt_output}, {31'h0, exp});
    endtask : wait_int

    initial begin
        {presetn, psel, penable, pwrite, ack_go} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        irq_primary = 8'h00;
        irq_secondary = 8'h00;
        miscompares = 0;
        tests_run = 0;
        cycles = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, PC, 8'h11);
        apb(1'b1, PD, 8'h20);
        apb(1'b1, PD, 8'h04);
        apb(1'b1, PD, 8'h01);
        apb(1'b1, SC, 8'h11);
        apb(1'b1, SD, 8'h28);
        apb(1'b1, SD, 8'h02);
        apb(1'b1, SD, 8'h01);
        apb(1'b0, PD, 8'h00);
        chk(rd, 32'h00000000);
        apb(1'b1, PD, 8'h28);
        apb(1'b0, PD, 8'h00);
        chk(rd, 32'h00000028);
        irq_primary <= 8'h28;
        wait_int(1'b0);
        apb(1'b1, PD, 8'h00);
        wait_int(1'b1);
        ack(8'h23);
        wait_int(1'b0);
        apb(1'b1, PC, 8'h0B);
        apb(1'b0, PC, 8'h00);
        chk(rd, 32'h00000008);
        apb(1'b1, PC, 8'h20);
        wait_int(1'b1);
        ack(8'h25);
        apb(1'b1, PC, 8'h20);
        irq_primary <= 8'h00;
        irq_secondary <= 8'h02;
        wait_int(1'b1);
        ack(8'h29);
        apb(1'b1, SC, 8'h20);
        apb(1'b1, PC, 8'h20);
        ack(8'h27);
        apb(1'b1, PC, 8'hC5);
        irq_primary <= 8'h48;
        wait_int(1'b1);
        ack(8'h26);
        apb(1'b1, PC, 8'hE6);
        apb(1'b1, PC, 8'h0C);
        apb(1'b0, PC, 8'h00);
        chk(rd, 32'h00000083);
        apb(1'b1, PC, 8'h20);
        apb(1'b0, 12'h004, 8'h00);
        chk({31'h0, err}, 32'h00000001);
        apb(1'b1, PC, 8'h11);
        apb(1'b1, PD, 8'h20);
        apb(1'b1, PD, 8'h04);
        apb(1'b1, PD, 8'h03);
        wait_int(1'b0);
        apb(1'b1, PC, 8'h80);
        irq_primary <= 8'h00;
        wait_int(1'b0);
        irq_primary <= 8'h48;
        wait_int(1'b1);
        ack(8'h23);
        apb(1'b1, PC, 8'h0B);
        apb(1'b0, PC, 8'h00);
        chk(rd, 32'h00000000);
        irq_primary <= 8'h40;
        wait_int(1'b1);
        irq_primary <= 8'h48;
        wait_int(1'b1);
        ack(8'h26);
        apb(1'b1, PC, 8'h11);
        apb(1'b1, PD, 8'h20);
        apb(1'b1, PD, 8'h04);
        apb(1'b1, PD, 8'h11);
        irq_secondary <= 8'h00;
        wait_int(1'b0);
        irq_secondary <= 8'h20;
        wait_int(1'b1);
        ack(8'h2D);
        irq_secondary <= 8'h22;
        wait_int(1'b1);
        ack(8'h29);
        apb(1'b1, SC, 8'h20);
        apb(1'b1, SC, 8'h0B);
        apb(1'b0, SC, 8'h00);
        chk(rd, 32'h00000020);
        apb(1'b1, SC, 8'h20);
        apb(1'b0, SC, 8'h00);
        chk(rd, 32'h00000000);
        apb(1'b1, PC, 8'hA0);
        apb(1'b1, TP, 8'hFF);
        apb(1'b0, TP, 8'h00);
        chk(rd, 32'h000000FA);
        apb(1'b1, TP, 8'h10);
        irq_primary <= 8'h59;
        wait_int(1'b1);
        ack(8'h24);
        irq_primary <= 8'h49;
        wait_int(1'b0);
        apb(1'b1, PC, 8'h20);
        wait_int(1'b1);
        ack(8'h20);
        apb(1'b1, PD, 8'h01);
        apb(1'b1, PC, 8'h68);
        irq_primary <= 8'h4B;
        wait_int(1'b1);
        ack(8'h21);
        complete_run();
    end
endmodule : cascaded_legacy_pic_programming_tb_top
